// File: cpu_io.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_io
    import nvm_access_pkg::*;
(
    // Core side
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic [7:0] rdata_i,
    output io_req_t req_o
);
    int to = 0;
    logic [7:0] x;
    initial req_o = '0;
    // One access once the stall is over, then an idle edge
    task automatic go(input io_req_t r, output logic [7:0] d);
        int n;
        n = 0;
        while (stall_i !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n == 20) to++;
        req_o = r;
        @(posedge clk_i);
        #1;
        d = rdata_i;
        req_o = '0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        go('{wr: 1'b1, addr: a, wdata: v, default: '0}, x);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        go('{rd: 1'b1, addr: a, default: '0}, d);
    endtask
    task automatic bop(input logic s, input logic [5:0] a, input logic [2:0] b);
        go('{bit_set: s, bit_clr: !s, addr: a, bit_sel: b, default: '0}, x);
    endtask
endmodule
`default_nettype wire

// File: nvm_access_pkg.sv
package nvm_access_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_DONE = 2'b10
    } wr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic [5:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [8:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

endpackage

// File: nvm_access_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"
module nvm_access_properties (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // I/O port
    input wire logic IO_WR_I,
    input wire logic IO_SBI_I,
    input wire logic IO_CBI_I,
    input wire logic [5:0] IO_ADDR_I,
    input wire logic [2:0] IO_BIT_I,
    input wire logic [7:0] IO_RDATA_O,
    input wire logic IO_HIT_O,
    input wire logic CPU_STALL_O,
    input wire logic RDY_IRQ_O
);
    wire logic ca = IO_ADDR_I == `CTRL_OFFSET;
    wire logic acc = ca && (IO_WR_I || IO_SBI_I || IO_CBI_I);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    a_hit_decode: assert property (
        IO_HIT_O == (IO_ADDR_I inside {[6'h01:6'h04]})) else $error("hit decode wrong");
    a_read_stall: assert property (
        IO_SBI_I && ca && IO_BIT_I == 3'h0 && !CPU_STALL_O && RDY_IRQ_O
        |=> CPU_STALL_O[*4] ##1 !CPU_STALL_O) else $error("read stall not four cycles");
    a_stall_len: assert property (
        $rose(CPU_STALL_O) |-> CPU_STALL_O[*2] ##[1:3] !CPU_STALL_O)
        else $error("stall length out of range");
    a_stall_cause: assert property (
        $rose(CPU_STALL_O) |-> $past(acc) || $past(acc, 2)) else $error("stall without access");
    a_ctrl_rsvd: assert property (
        $past(ca) && !CPU_STALL_O |-> IO_RDATA_O[7:4] == 4'h0 && !IO_RDATA_O[0])
        else $error("control reads back wrong");
    a_addr_rsvd: assert property (
        $past(IO_ADDR_I == `ADDR_HI_OFFSET) |-> IO_RDATA_O[7:1] == 7'h00)
        else $error("address high reserved bits set");
    a_irq_reset: assert property (
        $rose(NRST_I) |-> !RDY_IRQ_O && !CPU_STALL_O) else $error("outputs active after reset");
    a_irq_fall: assert property (
        $fell(RDY_IRQ_O) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
        else $error("ready dropped without cause");
    c_stall: cover property ($rose(CPU_STALL_O));
    c_irq: cover property ($fell(RDY_IRQ_O));
    c_bit: cover property (IO_SBI_I && IO_HIT_O);
endmodule
bind nvm_byte_access nvm_access_properties nvm_access_properties_inst (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .IO_WR_I(IO_WR_I), .IO_SBI_I(IO_SBI_I),
    .IO_CBI_I(IO_CBI_I), .IO_ADDR_I(IO_ADDR_I), .IO_BIT_I(IO_BIT_I),
    .IO_RDATA_O(IO_RDATA_O), .IO_HIT_O(IO_HIT_O), .CPU_STALL_O(CPU_STALL_O),
    .RDY_IRQ_O(RDY_IRQ_O));
`default_nettype wire

// File: nvm_access_regs.svh
`ifndef NVM_ACCESS_REGS_SVH
`define NVM_ACCESS_REGS_SVH

// I/O addresses of the access registers (bit-accessible range)
`define ADDR_LO_OFFSET 6'h01
`define ADDR_HI_OFFSET 6'h02
`define DATA_OFFSET 6'h03
`define CTRL_OFFSET 6'h04
`define BIT_IO_LAST 6'h1F

// Control register fields
`define CTRL_READ_BIT 0
`define CTRL_WRITE_BIT 1
`define CTRL_MASTER_BIT 2
`define CTRL_RDY_IE_BIT 3

// Reset values
`define CTRL_RESET 4'h0
`define DATA_RESET 8'h00
`define ADDR_RESET 9'h000

// Timing
`define READ_STALL_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define MASTER_WINDOW_CYCLES 3'h4
`define WRITE_RC_CYCLES 17'd67584
`define WRITE_TIME_US 8500
`define RC_SYNC_STAGES 2

`endif

// File: nvm_byte_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"

module nvm_byte_access
    import nvm_access_pkg::*;
(
    // Clock and resets
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic POR_NRST_I,
    // Processor I/O port
    input wire logic IO_WR_I,
    input wire logic IO_RD_I,
    input wire logic IO_SBI_I,
    input wire logic IO_CBI_I,
    input wire logic [5:0] IO_ADDR_I,
    input wire logic [2:0] IO_BIT_I,
    input wire logic [7:0] IO_WDATA_I,
    output logic [7:0] IO_RDATA_O,
    output logic IO_HIT_O,
    output logic CPU_STALL_O,
    // Power and timing
    input wire logic RC_CLK_I,
    input wire logic SLEEP_PD_I,
    output logic RC_KEEP_O,
    // Ready interrupt
    output logic RDY_IRQ_O
);
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
        logic rd_strobe;
        logic wr_strobe;
        logic master;
        logic rdy_ie;
        logic [2:0] master_cnt;
        logic [2:0] stall_cnt;
        logic [2:0] wr_stall;
        logic pd_keep;
        logic start;
        logic [7:0] rdata;
        wr_state_t st;
    } core_t;

    core_t r, next_r;
    io_req_t req;
    logic [7:0] mem [0:511];
    logic tmr_busy;
    logic tmr_done;
    logic [7:0] wval;
    logic [7:0] cur;
    logic wip;

    // Byte being programmed; only a power-on reset may clear it
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } prog_t;

    prog_t p, next_p;

    function automatic logic [7:0] bit_op(input logic [7:0] old, input io_req_t q);
        logic [7:0] v;
        v = q.wdata;
        if (q.bit_set || q.bit_clr) begin
            // Only the named bit changes
            v = old;
            v[q.bit_sel] = q.bit_set;
        end
        return v;
    endfunction

    function automatic logic [7:0] ctrl_view(input core_t c, input logic busy);
        return {4'h0, c.rdy_ie, c.master, busy, c.rd_strobe};
    endfunction

    assign req = '{wr: IO_WR_I, rd: IO_RD_I, bit_set: IO_SBI_I, bit_clr: IO_CBI_I,
                   addr: IO_ADDR_I, bit_sel: IO_BIT_I, wdata: IO_WDATA_I};

    nvm_write_timer u_timer (
        .clk(CLK_I),
        .nrst(POR_NRST_I),
        .rc_clk_i(RC_CLK_I),
        .start_i(r.start),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // Write stays in progress across a core reset until the timer ends it
    assign wip = r.wr_strobe || tmr_busy || tmr_done || (r.st == ST_WRITE);

    always_comb begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.rd_strobe = 1'b0;
        next_p = p;
        cur = 8'h00;
        case (req.addr)
            `ADDR_LO_OFFSET: cur = r.addr[7:0];
            `ADDR_HI_OFFSET: cur = {7'h00, r.addr[8]};
            `DATA_OFFSET: cur = r.data;
            `CTRL_OFFSET: cur = ctrl_view(r, wip);
            default: cur = 8'h00;
        endcase
        wval = bit_op(cur, req);
        next_r.rdata = cur;
        if (r.stall_cnt != 3'h0) begin
            next_r.stall_cnt = r.stall_cnt - 3'h1;
        end
        if (r.wr_stall != 3'h0) begin
            next_r.wr_stall = r.wr_stall - 3'h1;
        end
        if (r.master) begin
            if (r.master_cnt == `MASTER_WINDOW_CYCLES - 3'h1) begin
                next_r.master = 1'b0;
            end else begin
                next_r.master_cnt = r.master_cnt + 3'h1;
            end
        end
        if (SLEEP_PD_I && wip) begin
            next_r.pd_keep = 1'b1;
        end else if (!SLEEP_PD_I) begin
            next_r.pd_keep = 1'b0;
        end
        if ((req.wr || req.bit_set || req.bit_clr) && CPU_STALL_O == 1'b0) begin
            case (req.addr)
                `ADDR_LO_OFFSET: begin
                    if (!wip) next_r.addr[7:0] = wval;
                end
                `ADDR_HI_OFFSET: begin
                    if (!wip) next_r.addr[8] = wval[0];
                end
                `DATA_OFFSET: next_r.data = wval;
                `CTRL_OFFSET: begin
                    next_r.rdy_ie = wval[`CTRL_RDY_IE_BIT];
                    if (wval[`CTRL_MASTER_BIT] && !r.master) begin
                        next_r.master = 1'b1;
                        next_r.master_cnt = 3'h0;
                    end
                    if (wval[`CTRL_WRITE_BIT] && r.master && !wip) begin
                        next_r.wr_strobe = 1'b1;
                        next_p.addr = r.addr;
                        next_p.data = r.data;
                        next_r.start = 1'b1;
                        next_r.wr_stall = `WRITE_STALL_CYCLES;
                    end
                    if (wval[`CTRL_READ_BIT] && !wip) begin
                        next_r.data = mem[r.addr];
                        next_r.stall_cnt = `READ_STALL_CYCLES;
                    end
                end
                default: ;
            endcase
        end
        if (tmr_done) begin
            next_r.wr_strobe = 1'b0;
        end
        // Re-enters the write state after a core reset while the timer runs
        case (r.st)
            ST_IDLE: begin
                if (r.start || tmr_busy) begin
                    next_r.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (tmr_done) begin
                    next_r.st = ST_DONE;
                end
            end
            ST_DONE: begin
                next_r.st = ST_IDLE;
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    // Byte lands from the power-on domain copy, not from core registers
    always_ff @(posedge CLK_I) begin
        if (tmr_done) begin
            mem[p.addr] <= p.data;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Pending byte kept through a core reset
    always_ff @(posedge CLK_I or negedge POR_NRST_I) begin
        if (!POR_NRST_I) begin
            p <= '0;
        end else begin
            p <= next_p;
        end
    end

    assign IO_RDATA_O = r.rdata;
    assign IO_HIT_O = (IO_ADDR_I >= `ADDR_LO_OFFSET) && (IO_ADDR_I <= `CTRL_OFFSET);
    assign CPU_STALL_O = (r.stall_cnt != 3'h0) || (r.wr_stall != 3'h0);
    assign RC_KEEP_O = tmr_busy || r.pd_keep;
    assign RDY_IRQ_O = r.rdy_ie && !wip;
endmodule
`default_nettype wire

// File: nvm_write_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"

module nvm_write_timer
    import nvm_access_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic rc_clk_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic busy;
        logic done;
        logic [16:0] cnt;
    } tmr_t;

    tmr_t r, next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = rc_clk_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.done = 1'b0;
        if (start_i && !r.busy) begin
            next_r.busy = 1'b1;
            next_r.cnt = 17'd0;
        end else if (r.busy && r.s2 && !r.s3) begin
            // Count rising edges of the calibrated oscillator
            if (r.cnt == `WRITE_RC_CYCLES - 17'd1) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.cnt = r.cnt + 17'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy_o = r.busy;
    assign done_o = r.done;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_regs.svh"
module tb_top
    import nvm_access_pkg::*;
;
    localparam real WR_NS = `WRITE_RC_CYCLES * 8.2;
    logic clk = 1'b0, rc = 1'b0, nrst = 1'b0, por = 1'b0, pd = 1'b0;
    logic [7:0] rdata, d;
    logic hit, stall, keep, irq;
    io_req_t req;
    int n_fail = 0, checks = 0, nst = 0, n, n0;
    realtime t0;
    always #2 clk = ~clk;
    always #4.1 rc = ~rc;
    always @(posedge clk) if (stall === 1'b1) nst <= nst + 1;
    cpu_io cpu_io_inst (.clk_i(clk), .stall_i(stall), .rdata_i(rdata), .req_o(req));
    nvm_byte_access nvm_byte_access_inst (.CLK_I(clk), .NRST_I(nrst), .POR_NRST_I(por),
        .IO_WR_I(req.wr), .IO_RD_I(req.rd), .IO_SBI_I(req.bit_set), .IO_CBI_I(req.bit_clr),
        .IO_ADDR_I(req.addr), .IO_BIT_I(req.bit_sel), .IO_WDATA_I(req.wdata),
        .IO_RDATA_O(rdata), .IO_HIT_O(hit), .CPU_STALL_O(stall), .RC_CLK_I(rc),
        .SLEEP_PD_I(pd), .RC_KEEP_O(keep), .RDY_IRQ_O(irq));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t ns got %h expected %h", $time, g, e);
        end
    endtask
    task automatic results;
        n_fail += cpu_io_inst.to;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        por = 1'b1;
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h00);
        chk(irq, 1'h0);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h3);
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h08);
        chk(irq, 1'h1);
        cpu_io_inst.wr(`ADDR_LO_OFFSET, 8'hFF);
        cpu_io_inst.wr(`ADDR_HI_OFFSET, 8'h01);
        cpu_io_inst.rd(`ADDR_LO_OFFSET, d);
        chk(d, 8'hFF);
        cpu_io_inst.rd(`ADDR_HI_OFFSET, d);
        chk(d, 8'h01);
        $display("bit and address test done");
        n0 = nst;
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h0);
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h08);
        chk(8'(nst - n0), 8'h04);
        cpu_io_inst.bop(1'b0, `CTRL_OFFSET, 3'h3);
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h00);
        chk(irq, 1'h0);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h1);
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h00);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h2);
        repeat (6) @(posedge clk);
        #1;
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h1);
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h00);
        $display("read and master window test done");
        // One byte is programmed into flash here, with a core reset while it runs
        cpu_io_inst.wr(`DATA_OFFSET, 8'h5A);
        n0 = nst;
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h2);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h1);
        t0 = $realtime;
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d[1], 1'h1);
        chk(8'(nst - n0), 8'h02);
        cpu_io_inst.wr(`ADDR_LO_OFFSET, 8'h00);
        cpu_io_inst.rd(`ADDR_LO_OFFSET, d);
        chk(d, 8'hFF);
        cpu_io_inst.wr(`DATA_OFFSET, 8'hC3);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h0);
        cpu_io_inst.rd(`DATA_OFFSET, d);
        chk(d, 8'hC3);
        pd = 1'b1;
        chk(keep, 1'h1);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h3);
        chk(irq, 1'h0);
        n = 0;
        while (irq !== 1'b1 && n < 150000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(irq, 1'h1);
        chk(($realtime - t0 > WR_NS - 300) && ($realtime - t0 < WR_NS + 300), 1'h1);
        chk(keep, 1'h1);
        pd = 1'b0;
        cpu_io_inst.rd(`CTRL_OFFSET, d);
        chk(d, 8'h08);
        cpu_io_inst.wr(`ADDR_LO_OFFSET, 8'hFF);
        cpu_io_inst.wr(`ADDR_HI_OFFSET, 8'h01);
        cpu_io_inst.bop(1'b1, `CTRL_OFFSET, 3'h0);
        cpu_io_inst.rd(`DATA_OFFSET, d);
        chk(d, 8'h5A);
        pd = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(keep, 1'h0);
        $display("write test done");
        results();
    end
endmodule
`default_nettype wire
